// [design/fhr_top.sv]
// Fault history recorder: ground-fault imbalance trip, six-deep fault code history with
// run-time stamps on the four newest entries, run-time counter and AXI4-Lite registers.
// Assumes i_run, i_fault_valid and i_imbalance come from logic on the same clock.
// Operation
// - Trip and stop output on excess imbalance.
// - Level register 0 to 6553.5 %, reset 60.0.
// - Filter register 0 to 655.35 s, reset 0.10.
// - Log faults only while running.
// - Six-slot code shift, empty slots read zero.
// - Four stamps shift paired with codes.
// - Stamp day field counts 0 to 65535.
// - Minute field wraps after 1439, increments day.
// - Stamp captures run time at fault.
// - Time records are read-only to software.
//
// The AXI4-Lite register port and the register offsets were decided locally.
module fhr_top
    import fhr_pkg::*;
#(
    parameter int unsigned CODE_W = 8,
    parameter int unsigned TICKS_10MS = TICKS_PER_10MS
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_fault_valid,
    input wire logic [CODE_W-1:0] i_fault_code,
    input wire logic [15:0] i_imbalance,
    output logic o_gf_trip,
    output logic o_output_enable,
    output logic o_irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // The seconds prescaler counts a hundred times TICKS_10MS clocks, so that product must still fit 32 bits.
    if (CODE_W < 1 || CODE_W > 32 || TICKS_10MS < 1 || TICKS_10MS > 32'h028F_5C28) begin : g_bad_params
        $error("fhr_top: unsupported parameter values");
    end

    logic [15:0] gf_level_r;
    logic [15:0] gf_filter_r;
    logic [ST_BITS-1:0] status_r;
    logic [ST_BITS-1:0] irq_en_r;
    logic gf_trip_r;
    logic [31:0] tick_r;
    logic [15:0] filt_cnt_r;
    logic [31:0] sec_tick_r;
    logic [5:0] sec_r;
    logic [10:0] run_min_r;
    logic [15:0] run_day_r;
    logic [CODE_W-1:0] code_r [CODE_SLOTS];
    logic [10:0] stamp_min_r [STAMP_SLOTS];
    logic [15:0] stamp_day_r [STAMP_SLOTS];
    logic log_fault;
    logic over;
    logic ten_ms;
    logic one_sec;
    logic minute_tick;

    // Stored level is in 0.1 % steps, so the full 16-bit range covers 0 to 6553.5 %.
    assign over = i_imbalance > gf_level_r;
    assign log_fault = i_fault_valid && i_run;
    assign ten_ms = tick_r == TICKS_10MS - 1;
    assign o_gf_trip = gf_trip_r;
    assign o_output_enable = !gf_trip_r;
    assign o_irq = |(status_r & irq_en_r);

    // 10 ms tick used only by the filter, which counts in its own 0.01 s units.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_r <= '0;
        end else if (ten_ms) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick_r + 32'h1;
        end
    end

    // Any dip below the level restarts persistence; a zero filter trips at once.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            filt_cnt_r <= '0;
        end else if (!over) begin
            filt_cnt_r <= '0;
        end else if (ten_ms && filt_cnt_r != 16'hFFFF) begin
            filt_cnt_r <= filt_cnt_r + 16'h1;
        end
    end

    // The trip latches until reset so the output stays off after the event.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gf_trip_r <= 1'b0;
        end else if (over && filt_cnt_r >= gf_filter_r) begin
            gf_trip_r <= 1'b1;
        end
    end

    // Run-time seconds prescaler, held while stopped.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sec_tick_r <= '0;
        end else if (i_run) begin
            sec_tick_r <= one_sec ? '0 : sec_tick_r + 32'h1;
        end
    end
    assign one_sec = i_run && sec_tick_r == TICKS_10MS * TEN_MS_PER_SEC - 1;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sec_r <= '0;
        end else if (one_sec) begin
            sec_r <= (sec_r == SEC_LAST) ? '0 : sec_r + 6'h1;
        end
    end
    assign minute_tick = one_sec && sec_r == SEC_LAST;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_min_r <= '0;
            run_day_r <= '0;
        end else if (minute_tick) begin
            if (run_min_r == MINUTE_LAST) begin
                run_min_r <= '0;
                run_day_r <= run_day_r + 16'h1;
            end else begin
                run_min_r <= run_min_r + 11'h1;
            end
        end
    end

    // Code history shift chain; slot 0 is newest.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < CODE_SLOTS; i++) code_r[i] <= '0;
        end else if (log_fault) begin
            code_r[0] <= i_fault_code;
            for (int i = 1; i < CODE_SLOTS; i++) code_r[i] <= code_r[i-1];
        end
    end

    // Stamps shift in the same cycle as codes and take the run time now.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < STAMP_SLOTS; i++) begin
                stamp_min_r[i] <= '0;
                stamp_day_r[i] <= '0;
            end
        end else if (log_fault) begin
            stamp_min_r[0] <= run_min_r;
            stamp_day_r[0] <= run_day_r;
            for (int i = 1; i < STAMP_SLOTS; i++) begin
                stamp_min_r[i] <= stamp_min_r[i-1];
                stamp_day_r[i] <= stamp_day_r[i-1];
            end
        end
    end

    // AXI4-Lite write: address and data accepted in either order, one response each.
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;
    logic wr_hit;
    logic [31:0] clr_mask;

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit = awaddr_r == ADDR_GF_LEVEL || awaddr_r == ADDR_GF_FILTER
        || awaddr_r == ADDR_IRQ_EN || awaddr_r == ADDR_IRQ_CLR;
    assign clr_mask = (wr_go && awaddr_r == ADDR_IRQ_CLR && wstrb_r[0]) ? wdata_r : '0;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            // Read-only records answer SLVERR and stay untouched.
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only the two setting registers, the interrupt enable and the interrupt clear are writable; the first three are stored here.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gf_level_r <= GF_LEVEL_RST;
            gf_filter_r <= GF_FILTER_RST;
            irq_en_r <= '0;
        end else if (wr_go) begin
            if (awaddr_r == ADDR_GF_LEVEL) begin
                if (wstrb_r[0]) gf_level_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1]) gf_level_r[15:8] <= wdata_r[15:8];
            end
            if (awaddr_r == ADDR_GF_FILTER) begin
                if (wstrb_r[0]) gf_filter_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1]) gf_filter_r[15:8] <= wdata_r[15:8];
            end
            if (awaddr_r == ADDR_IRQ_EN && wstrb_r[0]) irq_en_r <= wdata_r[ST_BITS-1:0];
        end
    end

    // Sticky events: a set in the same cycle as a clear wins.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_r <= '0;
        end else begin
            for (int i = 0; i < ST_BITS; i++) begin
                if ((i == ST_GFTRIP && over && filt_cnt_r >= gf_filter_r && !gf_trip_r)
                    || (i == ST_LOGGED && log_fault)) begin
                    status_r[i] <= 1'b1;
                end else if (clr_mask[i]) begin
                    status_r[i] <= 1'b0;
                end
            end
        end
    end

    // AXI4-Lite read: one cycle from the address handshake to rvalid.
    logic [31:0] rd_mux;
    logic rd_ok;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        if (s_axi_araddr == ADDR_GF_LEVEL) rd_mux = {16'h0, gf_level_r};
        else if (s_axi_araddr == ADDR_GF_FILTER) rd_mux = {16'h0, gf_filter_r};
        else if (s_axi_araddr == ADDR_STATUS) rd_mux = {{(32-ST_BITS){1'b0}}, status_r};
        else if (s_axi_araddr == ADDR_IRQ_EN) rd_mux = {{(32-ST_BITS){1'b0}}, irq_en_r};
        else if (s_axi_araddr == ADDR_IRQ_CLR) rd_mux = '0;
        else if (s_axi_araddr == ADDR_RUN_MIN) rd_mux = {21'h0, run_min_r};
        else if (s_axi_araddr == ADDR_RUN_DAY) rd_mux = {16'h0, run_day_r};
        else begin
            rd_ok = 1'b0;
            for (int i = 0; i < CODE_SLOTS; i++) begin
                if (s_axi_araddr == ADDR_CODE0 + 8'(4 * i)) begin
                    rd_mux = 32'(code_r[i]);
                    rd_ok = 1'b1;
                end
            end
            for (int i = 0; i < STAMP_SLOTS; i++) begin
                if (s_axi_araddr == ADDR_STAMP0 + 8'(8 * i)) begin
                    rd_mux = {21'h0, stamp_min_r[i]};
                    rd_ok = 1'b1;
                end
                if (s_axi_araddr == ADDR_STAMP0 + 8'(8 * i + 4)) begin
                    rd_mux = {16'h0, stamp_day_r[i]};
                    rd_ok = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    property p_trip_stops;
        @(posedge i_clk) disable iff (!i_arst_n) gf_trip_r |=> gf_trip_r && !o_output_enable;
    endproperty
    a_trip_stops: assert property (p_trip_stops) else $error("trip without output stop");

    property p_no_trip_below;
        @(posedge i_clk) disable iff (!i_arst_n) !over && !gf_trip_r |=> !$rose(gf_trip_r);
    endproperty
    a_no_trip_below: assert property (p_no_trip_below) else $error("trip without imbalance");

    property p_filter_restart;
        @(posedge i_clk) disable iff (!i_arst_n) !over |=> filt_cnt_r == 16'h0;
    endproperty
    a_filter_restart: assert property (p_filter_restart) else $error("filter not restarted");

    property p_stopped_no_log;
        @(posedge i_clk) disable iff (!i_arst_n) i_fault_valid && !i_run |=> $stable(code_r[0]) && $stable(stamp_day_r[0]);
    endproperty
    a_stopped_no_log: assert property (p_stopped_no_log) else $error("fault logged while stopped");

    property p_code_shift;
        @(posedge i_clk) disable iff (!i_arst_n) log_fault |=> code_r[0] == $past(i_fault_code) && code_r[1] == $past(code_r[0]);
    endproperty
    a_code_shift: assert property (p_code_shift) else $error("code history not shifted");

    property p_stamp_pair;
        @(posedge i_clk) disable iff (!i_arst_n) log_fault |=> stamp_min_r[0] == $past(run_min_r) && stamp_min_r[1] == $past(stamp_min_r[0]);
    endproperty
    a_stamp_pair: assert property (p_stamp_pair) else $error("stamp not captured");

    property p_minute_range;
        @(posedge i_clk) disable iff (!i_arst_n) run_min_r <= MINUTE_LAST;
    endproperty
    a_minute_range: assert property (p_minute_range) else $error("minute out of range");

    property p_day_wrap;
        @(posedge i_clk) disable iff (!i_arst_n) minute_tick && run_min_r == MINUTE_LAST |=> run_min_r == 11'h0 && run_day_r == $past(run_day_r) + 16'h1;
    endproperty
    a_day_wrap: assert property (p_day_wrap) else $error("day rollover wrong");

    property p_hold_stopped;
        @(posedge i_clk) disable iff (!i_arst_n) !i_run |=> $stable(run_min_r) && $stable(sec_r);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("run time moved while stopped");
endmodule : fhr_top

// [design/fhr_pkg.sv]
// Package for the fault history recorder: register map, reset values and timing constants.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package fhr_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SEC_PER_MIN = 60;
    localparam int unsigned TEN_MS_PER_SEC = 100;
    localparam int unsigned TICKS_PER_10MS = CLK_HZ / TEN_MS_PER_SEC;
    localparam int unsigned MIN_PER_DAY = 1440;
    localparam logic [10:0] MINUTE_LAST = 11'h59F;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [15:0] GF_LEVEL_RST = 16'h0258;
    localparam logic [15:0] GF_FILTER_RST = 16'h000A;
    localparam int unsigned CODE_SLOTS = 6;
    localparam int unsigned STAMP_SLOTS = 4;
    localparam logic [7:0] ADDR_GF_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_GF_FILTER = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_RUN_MIN = 8'h14;
    localparam logic [7:0] ADDR_RUN_DAY = 8'h18;
    localparam logic [7:0] ADDR_CODE0 = 8'h20;
    localparam logic [7:0] ADDR_STAMP0 = 8'h40;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned ST_GFTRIP = 0;
    localparam int unsigned ST_LOGGED = 1;
    localparam int unsigned ST_BITS = 2;
endpackage : fhr_pkg

// [verification/test_fault_history_recorder.sv]
// Self-checking bench for the fault history recorder: registers, fault logging, run time, interrupt and trip.
// Assumes fhr_pkg and fhr_top are compiled first; the bench itself is the AXI4-Lite master.
module test_fault_history_recorder;
    timeunit 1ns;
    timeprecision 1ps;
    import fhr_pkg::*;
    // Two cycles per 10 ms tick keeps one minute of run time at 12000 cycles.
    localparam int unsigned TK = 2;
    localparam int unsigned MIN_CYC = TK * 100 * SEC_PER_MIN;
    logic i_clk, i_arst_n, i_run, i_fault_valid, o_gf_trip, o_output_enable, o_irq;
    logic [7:0] i_fault_code, s_axi_awaddr, s_axi_araddr;
    logic [15:0] i_imbalance;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_count = 0;
    int checks = 0;
    fhr_top #(.CODE_W(8), .TICKS_10MS(TK)) dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_run(i_run), .i_fault_valid(i_fault_valid),
        .i_fault_code(i_fault_code), .i_imbalance(i_imbalance), .o_gf_trip(o_gf_trip),
        .o_output_enable(o_output_enable), .o_irq(o_irq), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic close_out;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic hang(input string what);
        err_count++;
        $display("wrong value at %0t: %s timed out", $time, what);
        close_out();
    endtask : hang
    // Every bus task starts and ends just after a rising edge.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done, b_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        r = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 40 && !(aw_done && w_done); n++) begin
            @(posedge i_clk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && aw_done && w_done && !b_done; n++) begin
            @(posedge i_clk);
            if (s_axi_bvalid) begin
                b_done = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (!b_done) hang("write");
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic a_done, r_done;
        a_done = 1'b0;
        r_done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 40 && !a_done; n++) begin
            @(posedge i_clk);
            if (s_axi_arready) begin
                a_done = 1'b1;
                s_axi_arvalid <= 1'b0;
                s_axi_rready <= 1'b1;
            end
        end
        for (int n = 0; n < 40 && a_done && !r_done; n++) begin
            @(posedge i_clk);
            if (s_axi_rvalid) begin
                r_done = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
        if (!r_done) hang("read");
    endtask : axi_rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        axi_rd(a, rd, rs);
        chk(rd, exp, what);
        chk({30'h0, rs}, {30'h0, RESP_OKAY}, "read response");
    endtask : rd_chk
    task automatic faults(input logic [7:0] first, input int cnt);
        for (int k = 0; k < cnt; k++) begin
            i_fault_valid <= 1'b1;
            i_fault_code <= first + 8'(k);
            @(posedge i_clk);
        end
        i_fault_valid <= 1'b0;
    endtask : faults
    task automatic t_reset;
        rd_chk(ADDR_GF_LEVEL, {16'h0000, GF_LEVEL_RST}, "level after reset");
        rd_chk(ADDR_GF_FILTER, {16'h0000, GF_FILTER_RST}, "filter after reset");
        for (int i = 0; i < CODE_SLOTS; i++) rd_chk(ADDR_CODE0 + 8'(4 * i), 32'h0, "empty code slot");
        for (int i = 0; i < 2 * STAMP_SLOTS; i++) rd_chk(ADDR_STAMP0 + 8'(4 * i), 32'h0, "empty stamp");
        axi_rd(8'h1C, rd, rs);
        chk({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
        chk({29'h0, o_gf_trip, o_output_enable, o_irq}, 32'h2, "outputs after reset");
    endtask : t_reset
    task automatic t_regs;
        axi_wr(ADDR_GF_LEVEL, 32'h0000FFFF, rs);
        rd_chk(ADDR_GF_LEVEL, 32'h0000FFFF, "level top of range");
        axi_wr(ADDR_GF_FILTER, 32'h0000FFFF, rs);
        rd_chk(ADDR_GF_FILTER, 32'h0000FFFF, "filter top of range");
        axi_wr(ADDR_STAMP0, 32'h00001234, rs);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "write to stamp refused");
        axi_wr(ADDR_STAMP0 + 8'h04, 32'h00005678, rs);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "write to day refused");
        rd_chk(ADDR_STAMP0, 32'h0, "stamp minutes unchanged");
        rd_chk(ADDR_STAMP0 + 8'h04, 32'h0, "stamp days unchanged");
    endtask : t_regs
    task automatic t_log;
        faults(8'h55, 1);
        rd_chk(ADDR_CODE0, 32'h0, "fault while stopped");
        i_run <= 1'b1;
        faults(8'h21, 1);
        repeat (MIN_CYC - 20) @(posedge i_clk);
        i_run <= 1'b0;
        rd_chk(ADDR_RUN_MIN, 32'h0, "no minute before sixty seconds");
        i_run <= 1'b1;
        repeat (30) @(posedge i_clk);
        i_run <= 1'b0;
        rd_chk(ADDR_RUN_MIN, 32'h1, "one minute of run time");
        repeat (MIN_CYC + 100) @(posedge i_clk);
        rd_chk(ADDR_RUN_MIN, 32'h1, "run time held while stopped");
        rd_chk(ADDR_RUN_DAY, 32'h0, "run days");
        i_run <= 1'b1;
        faults(8'h22, 3);
        for (int i = 0; i < 4; i++) rd_chk(ADDR_CODE0 + 8'(4 * i), 32'(8'h24 - 8'(i)), "code order");
        for (int i = 0; i < 3; i++) rd_chk(ADDR_STAMP0 + 8'(8 * i), 32'h1, "stamp at one minute");
        rd_chk(ADDR_STAMP0 + 8'h18, 32'h0, "oldest stamp stays paired");
        rd_chk(ADDR_STAMP0 + 8'h1C, 32'h0, "oldest stamp day");
        faults(8'h25, 3);
        i_run <= 1'b0;
        for (int i = 0; i < CODE_SLOTS; i++) rd_chk(ADDR_CODE0 + 8'(4 * i), 32'(8'h27 - 8'(i)), "oldest dropped");
        rd_chk(ADDR_STAMP0 + 8'h18, 32'h1, "deepest stamp shifted");
    endtask : t_log
    task automatic t_irq;
        rd_chk(ADDR_STATUS, 32'h2, "logged status");
        axi_wr(ADDR_IRQ_EN, 32'h2, rs);
        chk({31'h0, o_irq}, 32'h1, "irq enabled");
        axi_wr(ADDR_IRQ_EN, 32'h0, rs);
        chk({31'h0, o_irq}, 32'h0, "irq masked");
        axi_wr(ADDR_IRQ_EN, 32'h2, rs);
        axi_wr(ADDR_IRQ_CLR, 32'h2, rs);
        chk({31'h0, o_irq}, 32'h0, "irq cleared");
        rd_chk(ADDR_STATUS, 32'h0, "status cleared");
    endtask : t_irq
    task automatic t_trip;
        axi_wr(ADDR_GF_LEVEL, 32'h64, rs);
        axi_wr(ADDR_GF_FILTER, 32'h3, rs);
        axi_wr(ADDR_IRQ_EN, 32'h1, rs);
        i_imbalance <= 16'h0064;
        repeat (20) @(posedge i_clk);
        chk({31'h0, o_gf_trip}, 32'h0, "level equal is no trip");
        // Two excursions of two ticks each would trip a filter that failed to restart.
        i_imbalance <= 16'h0065;
        repeat (4) @(posedge i_clk);
        i_imbalance <= 16'h0000;
        repeat (2) @(posedge i_clk);
        i_imbalance <= 16'h0065;
        repeat (4) @(posedge i_clk);
        chk({31'h0, o_gf_trip}, 32'h0, "short excursion restarts filter");
        for (int n = 0; n < 20 && o_gf_trip !== 1'b1; n++) @(posedge i_clk);
        chk({30'h0, o_gf_trip, o_output_enable}, 32'h2, "trip stops output");
        chk({31'h0, o_irq}, 32'h1, "trip interrupt");
        rd_chk(ADDR_STATUS, 32'h1, "trip status");
    endtask : t_trip
    initial begin
        i_arst_n = 1'b0;
        {i_run, i_fault_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
        i_fault_code = 8'h00;
        i_imbalance = 16'h0000;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_regs();
        t_log();
        t_irq();
        t_trip();
        close_out();
    end
endmodule : test_fault_history_recorder
